// [inc/region_pkg.sv]
// package: address map, register map and route codes for the region decoder
// Overview of operation
// - below 512KB to main memory, except qualified SMRAM hits with SMRAM disabled
// - 080000h-09FFFFh to memory or PCI, programmable
// - graphics range to PCI; default management memory
// - C0000h-DFFFFh in 16KB segments with attributes
// - four E-segment blocks with read/write enables
// - F-segment single block, read/write enables
// - after reset top BIOS block goes PCI
// - DRAM above 1MB; optional 1MB hole at 15MB
// - high BIOS enabled at reset, to PCI
// - local interrupt controller range left unclaimed
// - sixteen interrupt units at FECx0000h
// - 4GB-64GB claimed, writes dropped, reads zero
// - shadow copy: reads ROM, writes RAM
// - inbound hits on shadowed blocks not snooped
// - SMRAM disabled: qualified accesses to the management range ignored
// - SMRAM enabled: qualified management range goes to DRAM
// - top 20MB below 4GB is PCI memory, except the local interrupt controller range
package region_pkg;
    // ----------------------------------------
    // address map
    // ----------------------------------------
    localparam int          ADDR_W       = 36;
    localparam logic [35:0] DOS_END      = 36'h0_0007_FFFF;
    localparam logic [35:0] ISA_WIN_END  = 36'h0_0009_FFFF;
    localparam logic [35:0] VGA_END      = 36'h0_000B_FFFF;
    localparam logic [35:0] LEGACY_END   = 36'h0_000F_FFFF;
    localparam logic [35:0] HOLE_BASE    = 36'h0_00F0_0000;
    localparam logic [35:0] HOLE_END     = 36'h0_00FF_FFFF;
    localparam logic [35:0] PCI_TOP_BASE = 36'h0_FEC0_0000;
    localparam logic [35:0] LAPIC_BASE   = 36'h0_FEE0_0000;
    localparam logic [35:0] LAPIC_END    = 36'h0_FEE0_1000;
    localparam logic [35:0] HIBIOS_BASE  = 36'h0_FFFE_0000;
    localparam logic [11:0] IOAPIC_TAG   = 12'hFEC;
    localparam int          SMRAM_SH     = 17;
    localparam int          NSEG         = 13;
    localparam int          F_SEG        = 12;
    // ----------------------------------------
    // register map and reset values
    // ----------------------------------------
    localparam logic [7:0]  OFS_RD_EN    = 8'h00;
    localparam logic [7:0]  OFS_WR_EN    = 8'h04;
    localparam logic [7:0]  OFS_CTRL     = 8'h08;
    localparam logic [7:0]  OFS_SMBASE   = 8'h0C;
    localparam logic [7:0]  OFS_TOM      = 8'h10;
    localparam logic [7:0]  OFS_STATUS   = 8'h14;
    localparam int          CTL_ISA_DRAM = 0;
    localparam int          CTL_HOLE_PCI = 1;
    localparam int          CTL_HIBIOS   = 2;
    localparam int          CTL_SMRAM_EN = 3;
    localparam logic [3:0]  CTRL_RST     = 4'h5;
    localparam logic [12:0] ATTR_RST     = 13'h0000;
    localparam logic [14:0] SMBASE_RST   = 15'h0005;
    localparam logic [11:0] TOM_MB_RST   = 12'h040;
    typedef enum logic [1:0] {
        ROUTE_DRAM,
        ROUTE_PCI,
        ROUTE_NONE,
        ROUTE_TERM
    } route_t;
endpackage : region_pkg

// [rtl/shadow_attr_lookup.sv]
// module: segment attribute lookup for the C, D, E and F legacy blocks
`timescale 1ns/1ps
`default_nettype none
module shadow_attr_lookup
    import region_pkg::*;
(
    input  wire logic [31:0]     addr_i,
    input  wire logic [NSEG-1:0] read_en_i,
    input  wire logic [NSEG-1:0] write_en_i,
    output logic                 hit_o,
    output logic                 re_o,
    output logic                 we_o
);
    logic [3:0] idx;

    // ----------------------------------------
    // segment select
    // ----------------------------------------
    always_comb begin
        hit_o = (addr_i[31:20] == 12'h000) && (addr_i[19:18] == 2'b11);
        idx   = addr_i[17:14];
        if (idx >= 4'(F_SEG)) begin
            idx = 4'(F_SEG);
        end
        re_o  = hit_o && read_en_i[idx];
        we_o  = hit_o && write_en_i[idx];
    end
endmodule : shadow_attr_lookup
`default_nettype wire

// [rtl/host_address_region_decoder.sv]
// module: processor memory request region decoder with wishbone registers
`timescale 1ns/1ps
`default_nettype none
module host_address_region_decoder
    import region_pkg::*;
#(
    parameter logic [11:0] TOM_MB_DEF = TOM_MB_RST
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              req_valid_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic              req_write_i,
    input  wire logic              mgmt_memory_qualifier_n_i,
    output logic                   route_valid_o,
    output logic                   route_dram_o,
    output logic                   route_pci_o,
    output logic                   route_none_o,
    output logic                   route_term_o,
    output logic                   read_zero_o,
    output logic                   ioapic_hit_o,
    output logic [3:0]             ioapic_unit_o,
    input  wire logic              inb_valid_i,
    input  wire logic [31:0]       inb_addr_i,
    input  wire logic              inb_write_i,
    output logic                   inb_done_o,
    output logic                   inb_snoop_o
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [NSEG-1:0]   attr_re;
    logic [NSEG-1:0]   attr_we;
    logic [3:0]        ctrl;
    logic [14:0]       smbase;
    logic [11:0]       tom_mb;
    logic [15:0]       term_count;
    route_t            last_route;
    logic              pend;
    logic [ADDR_W-1:0] req_addr;
    logic              req_write;
    logic              lk_hit;
    logic              lk_re;
    logic              lk_we;
    logic              ib_hit;
    logic              ib_re;
    logic              ib_we;
    logic              smm_qual;
    logic              in_smram;
    logic              above_4g;
    logic              in_lapic;
    logic              is_ioapic;
    logic              inb_shadow;
    logic              wb_req;
    route_t            next_route;
    logic [31:0]       rd_mux;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            attr_re <= ATTR_RST;
            attr_we <= ATTR_RST;
            ctrl    <= CTRL_RST;
            smbase  <= SMBASE_RST;
            tom_mb  <= TOM_MB_DEF;
        end else if (wb_req && wb_we_i) begin
            unique case (wb_adr_i)
                OFS_RD_EN: attr_re <= NSEG'(merge(32'(attr_re), wb_dat_i, wb_sel_i));
                OFS_WR_EN: attr_we <= NSEG'(merge(32'(attr_we), wb_dat_i, wb_sel_i));
                OFS_CTRL: ctrl <= 4'(merge(32'(ctrl), wb_dat_i, wb_sel_i));
                OFS_SMBASE: smbase <= 15'(merge(32'(smbase), wb_dat_i, wb_sel_i));
                OFS_TOM: tom_mb <= 12'(merge(32'(tom_mb), wb_dat_i, wb_sel_i));
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        unique case (wb_adr_i)
            OFS_RD_EN: rd_mux = 32'(attr_re);
            OFS_WR_EN: rd_mux = 32'(attr_we);
            OFS_CTRL: rd_mux = 32'(ctrl);
            OFS_SMBASE: rd_mux = 32'(smbase);
            OFS_TOM: rd_mux = 32'(tom_mb);
            OFS_STATUS: rd_mux = {term_count, 14'h0000, last_route};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_mux;
        end
    end

    // ----------------------------------------
    // request phase capture
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend      <= 1'b0;
            req_addr  <= '0;
            req_write <= 1'b0;
        end else if (req_valid_i && !pend) begin
            pend      <= 1'b1;
            req_addr  <= req_addr_i;
            req_write <= req_write_i;
        end else begin
            pend      <= 1'b0;
        end
    end

    shadow_attr_lookup u_cpu_lookup (
        .addr_i     (req_addr[31:0]),
        .read_en_i  (attr_re),
        .write_en_i (attr_we),
        .hit_o      (lk_hit),
        .re_o       (lk_re),
        .we_o       (lk_we)
    );

    shadow_attr_lookup u_inb_lookup (
        .addr_i     (inb_addr_i),
        .read_en_i  (attr_re),
        .write_en_i (attr_we),
        .hit_o      (ib_hit),
        .re_o       (ib_re),
        .we_o       (ib_we)
    );

    // ----------------------------------------
    // region decode
    // ----------------------------------------
    assign smm_qual  = pend && !mgmt_memory_qualifier_n_i;
    assign in_smram  = (req_addr[ADDR_W-1:SMRAM_SH] == 19'(smbase));
    assign above_4g  = (req_addr[ADDR_W-1:32] != 4'h0);
    assign in_lapic  = (req_addr >= LAPIC_BASE) && (req_addr <= LAPIC_END);
    assign is_ioapic = !above_4g && (req_addr[31:20] == IOAPIC_TAG);

    always_comb begin
        if (above_4g) begin
            next_route = ROUTE_TERM;
        end else if (smm_qual && in_smram) begin
            next_route = ctrl[CTL_SMRAM_EN] ? ROUTE_DRAM : ROUTE_NONE;
        end else if (in_lapic) begin
            next_route = ROUTE_NONE;
        end else if (req_addr >= HIBIOS_BASE) begin
            next_route = ctrl[CTL_HIBIOS] ? ROUTE_PCI : ROUTE_NONE;
        end else if (req_addr >= PCI_TOP_BASE) begin
            next_route = ROUTE_PCI;
        end else if (req_addr <= DOS_END) begin
            next_route = ROUTE_DRAM;
        end else if (req_addr <= ISA_WIN_END) begin
            next_route = ctrl[CTL_ISA_DRAM] ? ROUTE_DRAM : ROUTE_PCI;
        end else if (req_addr <= VGA_END) begin
            next_route = ROUTE_PCI;
        end else if (lk_hit) begin
            if (req_write ? lk_we : lk_re) begin
                next_route = ROUTE_DRAM;
            end else begin
                next_route = ROUTE_PCI;
            end
        end else if (req_addr >= HOLE_BASE && req_addr <= HOLE_END && ctrl[CTL_HOLE_PCI]) begin
            next_route = ROUTE_PCI;
        end else if (req_addr[31:20] < tom_mb) begin
            next_route = ROUTE_DRAM;
        end else begin
            next_route = ROUTE_PCI;
        end
    end

    // ----------------------------------------
    // answer registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_valid_o <= 1'b0;
            route_dram_o  <= 1'b0;
            route_pci_o   <= 1'b0;
            route_none_o  <= 1'b0;
            route_term_o  <= 1'b0;
            read_zero_o   <= 1'b0;
            ioapic_hit_o  <= 1'b0;
            ioapic_unit_o <= 4'h0;
        end else begin
            route_valid_o <= pend;
            route_dram_o  <= pend && (next_route == ROUTE_DRAM);
            route_pci_o   <= pend && (next_route == ROUTE_PCI);
            route_none_o  <= pend && (next_route == ROUTE_NONE);
            route_term_o  <= pend && (next_route == ROUTE_TERM);
            read_zero_o   <= pend && (next_route == ROUTE_TERM) && !req_write;
            ioapic_hit_o  <= pend && is_ioapic && (next_route == ROUTE_PCI);
            ioapic_unit_o <= pend ? req_addr[19:16] : 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_route <= ROUTE_PCI;
            term_count <= 16'h0000;
        end else if (pend) begin
            last_route <= next_route;
            if (next_route == ROUTE_TERM) begin
                term_count <= term_count + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // inbound snoop filter
    // ----------------------------------------
    assign inb_shadow = ib_hit && (inb_write_i ? ib_we : ib_re);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inb_done_o  <= 1'b0;
            inb_snoop_o <= 1'b0;
        end else begin
            inb_done_o  <= inb_valid_i;
            inb_snoop_o <= inb_valid_i && !inb_shadow;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req_phase;
        req_valid_i && !pend;
    endsequence

    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    a_req_answer: assert property (s_req_phase |-> ##2 route_valid_o)
        else $error("request not answered two cycles later");
    a_bus_ack: assert property (s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");
    a_dos_dram: assert property (pend && !above_4g && req_addr <= DOS_END
        && !(smm_qual && in_smram) |=> route_dram_o)
        else $error("low region not sent to memory");
    a_above_term: assert property (pend && above_4g && !req_write
        |=> route_term_o && read_zero_o && !route_dram_o)
        else $error("upper access not terminated with zero");
    a_lapic_none: assert property (pend && in_lapic && !above_4g
        && !(smm_qual && in_smram) |=> route_none_o)
        else $error("local interrupt range claimed");
    a_smm_off: assert property (smm_qual && in_smram && !above_4g
        && !ctrl[CTL_SMRAM_EN] |=> route_none_o && !route_pci_o)
        else $error("qualified access claimed with smram off");
    a_smm_on: assert property (smm_qual && in_smram && !above_4g
        && ctrl[CTL_SMRAM_EN] |=> route_dram_o)
        else $error("qualified access not sent to memory");
    a_boot_pci: assert property (pend && lk_hit && !req_write && !attr_re[F_SEG] && !above_4g
        && req_addr[17:16] == 2'b11 && !smm_qual |=> route_pci_o)
        else $error("top block read not sent to pci");
    a_shadow_copy: assert property (pend && lk_hit && req_write && lk_we && !above_4g
        && !smm_qual |=> route_dram_o)
        else $error("shadow write not sent to memory");
    a_inb_hidden: assert property (inb_valid_i && inb_shadow |=> inb_done_o
        && !inb_snoop_o)
        else $error("shadowed inbound snooped");
    a_ioapic_unit: assert property (pend && is_ioapic && !in_lapic && !(smm_qual && in_smram)
        |=> ioapic_hit_o && ioapic_unit_o == $past(req_addr[19:16]))
        else $error("interrupt unit select wrong");
endmodule : host_address_region_decoder
`default_nettype wire

// [dv/proc_bus_agent.sv]
// file: processor bus agent model issuing memory requests
`timescale 1ns/1ps
`default_nettype none
module proc_bus_agent
    import region_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              go_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              write_i,
    input  wire logic              smm_i,
    output logic                   req_valid_o,
    output logic [ADDR_W-1:0]      req_addr_o,
    output logic                   req_write_o,
    output logic                   qual_n_o
);
    logic smm_q;
    // ----------------------------------------
    // request phase, first clock
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_valid_o <= 1'b0;
            req_addr_o  <= '0;
            req_write_o <= 1'b0;
            smm_q       <= 1'b0;
        end else if (go_i) begin
            req_valid_o <= 1'b1;
            req_addr_o  <= addr_i;
            req_write_o <= write_i;
            smm_q       <= smm_i;
        end else begin
            req_valid_o <= 1'b0;
            req_addr_o  <= ~req_addr_o;
            req_write_o <= ~req_write_o;
        end
    end
    // ----------------------------------------
    // qualifier in second clock, high otherwise
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            qual_n_o <= 1'b1;
        end else begin
            qual_n_o <= !(req_valid_o && smm_q);
        end
    end
endmodule : proc_bus_agent
`default_nettype wire

// [dv/host_address_region_decoder_tb.sv]
// file: self-checking testbench for the region decoder
`timescale 1ns/1ps
`default_nettype none
module host_address_region_decoder_tb
    import region_pkg::*;
;
    logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]        wb_adr_i;
    logic [3:0]        wb_sel_i, ioapic_unit_o;
    logic [31:0]       wb_dat_i, wb_dat_o, inb_addr_i, sel_q;
    logic              req_valid_i, req_write_i, qual_n, go, p_wr, p_smm;
    logic [ADDR_W-1:0] req_addr_i, p_addr;
    logic              route_valid_o, route_dram_o, route_pci_o, route_none_o, route_term_o;
    logic              read_zero_o, ioapic_hit_o, inb_valid_i, inb_write_i;
    logic              inb_done_o, inb_snoop_o;
    int                errors, checked, cycles;

    host_address_region_decoder i_host_address_region_decoder (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
        .req_addr_i(req_addr_i), .req_write_i(req_write_i),
        .mgmt_memory_qualifier_n_i(qual_n), .route_valid_o(route_valid_o),
        .route_dram_o(route_dram_o), .route_pci_o(route_pci_o), .route_none_o(route_none_o),
        .route_term_o(route_term_o), .read_zero_o(read_zero_o), .ioapic_hit_o(ioapic_hit_o),
        .ioapic_unit_o(ioapic_unit_o), .inb_valid_i(inb_valid_i), .inb_addr_i(inb_addr_i),
        .inb_write_i(inb_write_i), .inb_done_o(inb_done_o), .inb_snoop_o(inb_snoop_o));

    proc_bus_agent i_proc_bus_agent (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .addr_i(p_addr), .write_i(p_wr),
        .smm_i(p_smm), .req_valid_o(req_valid_i), .req_addr_o(req_addr_i),
        .req_write_o(req_write_i), .qual_n_o(qual_n));

    always #50 clk_i = ~clk_i;
    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task automatic summarize;
        $display("checked %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task automatic cmp_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : cmp_reg
    task automatic cmp_flag(input string n, input logic [3:0] e, input logic [3:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : cmp_flag
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hF, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, 4'hF, q);
        cmp_reg($sformatf("reg %h", a), e, q);
    endtask : rd
    task automatic req(input logic [35:0] a, input logic w, input logic s,
                       input route_t r, input logic z);
        int   n;
        logic io;
        n = 0;
        io = (r == ROUTE_PCI) && (a[35:20] == 16'h0FEC);
        go     <= 1'b1;
        p_addr <= a;
        p_wr   <= w;
        p_smm  <= s;
        @(posedge clk_i);
        go <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (route_valid_o !== 1'b1 && n < 8);
        cmp_flag("answer_delay", 4'h3, 4'(n));
        cmp_flag("route", 4'h1 << r, {route_term_o, route_none_o, route_pci_o, route_dram_o});
        cmp_flag("read_zero", {3'h0, z}, {3'h0, read_zero_o});
        cmp_flag("ioapic_hit", {3'h0, io}, {3'h0, ioapic_hit_o});
        cmp_flag("ioapic_unit", a[19:16], ioapic_unit_o);
        @(posedge clk_i);
        cmp_flag("route_valid", 4'h0, {3'h0, route_valid_o});
    endtask : req
    task automatic inb(input logic [31:0] a, input logic sa, input logic [31:0] b,
                       input logic sb);
        inb_valid_i <= 1'b1;
        inb_addr_i  <= a;
        @(posedge clk_i);
        inb_addr_i <= b;
        @(posedge clk_i);
        inb_valid_i <= 1'b0;
        inb_addr_i  <= ~b;
        cmp_flag("inb_a", {2'h0, 1'b1, sa}, {2'h0, inb_done_o, inb_snoop_o});
        @(posedge clk_i);
        cmp_flag("inb_b", {2'h0, 1'b1, sb}, {2'h0, inb_done_o, inb_snoop_o});
    endtask : inb
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, go, p_wr, p_smm, inb_valid_i, inb_write_i} = '0;
        {wb_adr_i, wb_sel_i, wb_dat_i, p_addr, inb_addr_i, errors, checked, cycles} = '0;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(OFS_RD_EN, 32'h0);
        rd(OFS_WR_EN, 32'h0);
        rd(OFS_CTRL, 32'h5);
        rd(OFS_SMBASE, 32'h5);
        rd(OFS_TOM, 32'h40);
        wr(8'h18, 32'hFFFF_FFFF);
        rd(8'h18, 32'h0);
        $display("test reset_registers done");
        req(36'h0_0007_FFFF, 1'b0, 1'b0, ROUTE_DRAM, 1'b0);
        req(36'h0_0009_FFFF, 1'b1, 1'b0, ROUTE_DRAM, 1'b0);
        req(36'h0_000A_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_000C_0000, 1'b1, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_000E_C000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_000F_FFF0, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_0010_0000, 1'b1, 1'b0, ROUTE_DRAM, 1'b0);
        req(36'h0_00F0_0000, 1'b0, 1'b0, ROUTE_DRAM, 1'b0);
        req(36'h0_03FF_FFFF, 1'b0, 1'b0, ROUTE_DRAM, 1'b0);
        req(36'h0_0400_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_FFFE_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_FEE0_0000, 1'b0, 1'b0, ROUTE_NONE, 1'b0);
        req(36'h0_FEE0_1000, 1'b1, 1'b0, ROUTE_NONE, 1'b0);
        req(36'h0_FEC0_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_FECF_0000, 1'b1, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_FED0_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h1_0000_0000, 1'b0, 1'b0, ROUTE_TERM, 1'b1);
        req(36'hF_FFFF_FFFF, 1'b1, 1'b0, ROUTE_TERM, 1'b0);
        rd(OFS_STATUS, 32'h0002_0003);
        $display("test default_map done");
        wr(OFS_CTRL, 32'h2);
        wb(1'b1, OFS_CTRL, 32'h0000_0F00, 4'h1, sel_q);
        rd(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h2);
        req(36'h0_0008_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_00F0_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_0100_0000, 1'b0, 1'b0, ROUTE_DRAM, 1'b0);
        req(36'h0_FFFE_0000, 1'b0, 1'b0, ROUTE_NONE, 1'b0);
        req(36'h0_000A_0000, 1'b0, 1'b1, ROUTE_NONE, 1'b0);
        wr(OFS_CTRL, 32'hA);
        req(36'h0_000A_0000, 1'b1, 1'b1, ROUTE_DRAM, 1'b0);
        req(36'h0_000B_FFFF, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        wr(OFS_SMBASE, 32'h7F60);
        req(36'h0_FEC0_0000, 1'b0, 1'b1, ROUTE_DRAM, 1'b0);
        req(36'h0_000A_0000, 1'b0, 1'b1, ROUTE_PCI, 1'b0);
        wr(OFS_TOM, 32'h20);
        req(36'h0_01FF_FFFF, 1'b0, 1'b0, ROUTE_DRAM, 1'b0);
        req(36'h0_0200_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        $display("test programmed_map done");
        wr(OFS_WR_EN, 32'h1000);
        req(36'h0_000F_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_000F_0000, 1'b1, 1'b0, ROUTE_DRAM, 1'b0);
        wr(OFS_RD_EN, 32'h1208);
        wr(OFS_WR_EN, 32'h0);
        req(36'h0_000F_8000, 1'b0, 1'b0, ROUTE_DRAM, 1'b0);
        req(36'h0_000F_8000, 1'b1, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_000E_4000, 1'b0, 1'b0, ROUTE_DRAM, 1'b0);
        req(36'h0_000E_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        req(36'h0_000C_C000, 1'b0, 1'b0, ROUTE_DRAM, 1'b0);
        req(36'h0_000C_8000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        inb(32'h000F_0000, 1'b0, 32'h000C_8000, 1'b1);
        wr(OFS_WR_EN, 32'h0004);
        inb_write_i <= 1'b1;
        inb(32'h000C_8000, 1'b0, 32'h000F_0000, 1'b1);
        $display("test shadowing done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(OFS_CTRL, 32'h5);
        rd(OFS_RD_EN, 32'h0);
        rd(OFS_STATUS, 32'h0000_0001);
        req(36'h0_000F_0000, 1'b0, 1'b0, ROUTE_PCI, 1'b0);
        $display("test mid_reset done");
        summarize();
    end
endmodule : host_address_region_decoder_tb
`default_nettype wire
